// ==== rtl/ppap_pkg.sv ====
// package: register map, field positions and reset values of the parallel port address/pin block
package ppap_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the AXI4-Lite slave)
  // ----------------------------------------------------------------
  localparam logic [3:0]  PPAP_OFS_TARGET_ADDR = 4'h0;
  localparam logic [3:0]  PPAP_OFS_PIN_ENABLE  = 4'h4;
  localparam logic [3:0]  PPAP_OFS_PORT_CTRL   = 4'h8;
  localparam logic [3:0]  PPAP_OFS_STATUS      = 4'hC;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int          PPAP_BIT_CS2         = 15;
  localparam int          PPAP_BIT_CS1         = 14;
  localparam int          PPAP_ADDR_MSB        = 13;
  localparam int          PPAP_CTRL_MUX_CS     = 0;  // 1: upper pins carry chip selects
  localparam int          PPAP_CTRL_MUX_ALE    = 1;  // 1: lower pins carry latch strobes
  localparam int          PPAP_CTRL_START      = 2;  // write 1 starts one transfer

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [15:0] PPAP_RST_TARGET_ADDR = 16'h0000;
  localparam logic [15:0] PPAP_RST_PIN_ENABLE  = 16'h0000;
  localparam logic [1:0]  PPAP_RST_PORT_CTRL   = 2'h0;
  localparam logic [3:0]  PPAP_XFER_CYCLES     = 4'h4;
  localparam logic [1:0]  PPAP_RESP_OKAY       = 2'h0;
  localparam logic [1:0]  PPAP_RESP_SLVERR     = 2'h2;

endpackage : ppap_pkg

// ==== rtl/ppap_pin_mux.sv ====
// module: per-pin function select between parallel port and general I/O
`timescale 1ns/10ps

module ppap_pin_mux
  import ppap_pkg::*;
(
  // selection
  input  wire logic [15:0] pin_enable,
  input  wire logic [15:0] port_value,
  input  wire logic        drive_active,
  // general purpose I/O side
  input  wire logic [15:0] gpio_out,
  input  wire logic [15:0] gpio_oe,
  // pad side
  output logic      [15:0] pad_out,
  output logic      [15:0] pad_oe
);

  genvar i;
  generate
    for (i = 0; i < 16; i++) begin : g_pin
      // a disabled pin is left wholly to the ordinary port logic
      always_comb begin
        if (pin_enable[i]) begin                              // see RL4 RL5 RL6
          pad_out[i] = port_value[i];
          pad_oe[i]  = drive_active;                          // see RL7
        end else begin
          pad_out[i] = gpio_out[i];
          pad_oe[i]  = gpio_oe[i];
        end
      end
    end
  endgenerate

endmodule // ppap_pin_mux

// ==== rtl/ppap_top.sv ====
// module: parallel port address and pin-enable block with AXI4-Lite registers
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps

// Overview of operation
// RL1: target address bit 15 drives the second chip select, active when 1.
// RL2: target address bit 14 drives the first chip select, active when 1.
// RL3: low fourteen bits hold the read/write destination address.
// RL4: enable bits 15:14 give top pins to address or chip selects, else I/O. Code drives 0 there instead of address.
// RL5: enable bits 13:2 give each pin its address line, else I/O.
// RL6: enable bits 1:0 give low pins to address or latch strobes, else I/O.
// RL7: during a transfer only enabled pins are driven; others stay ordinary I/O.
module ppap_top
  import ppap_pkg::*;
(
  // clock, reset, enable
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  wire logic        CLK_EN,
  // axi4-lite write address
  input  wire logic [3:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  // axi4-lite write data
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  // axi4-lite write response
  output logic      [1:0]  BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  // axi4-lite read address
  input  wire logic [3:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  // axi4-lite read data
  output logic      [31:0] RDATA,
  output logic      [1:0]  RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  // general purpose I/O requests for the shared pins
  input  wire logic [15:0] GPIO_OUT,
  input  wire logic [15:0] GPIO_OE,
  // port pads
  output logic      [15:0] PORT_ADDRESS_PIN_OUT,
  output logic      [15:0] PORT_ADDRESS_PIN_OE,
  // strobes toward the rest of the port
  output logic             PORT_CHIP_SELECT_SECOND,
  output logic             PORT_CHIP_SELECT_FIRST,
  output logic             ADDRESS_LATCH_HIGH_STROBE,
  output logic             ADDRESS_LATCH_LOW_STROBE,
  output logic             TRANSFER_BUSY
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0] port_target_address;
  logic [15:0] port_pin_function_enable;
  logic [1:0]  port_ctrl;
  logic [3:0]  xfer_cnt;
  logic        busy;
  logic [3:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        aw_held;
  logic        w_held;
  logic        do_write;
  logic        start_req;
  logic [15:0] next_field;

  // named field views
  logic        chip_select_second;
  logic        chip_select_first;
  logic [1:0]  upper_pin_strobe_enable;
  logic [11:0] middle_address_pin_enable;
  logic [1:0]  lower_pin_latch_enable;

  assign chip_select_second        = port_target_address[PPAP_BIT_CS2];    // see RL1
  assign chip_select_first         = port_target_address[PPAP_BIT_CS1];    // see RL2
  assign upper_pin_strobe_enable   = port_pin_function_enable[15:14];
  assign middle_address_pin_enable = port_pin_function_enable[13:2];
  assign lower_pin_latch_enable    = port_pin_function_enable[1:0];

  // ----------------------------------------------------------------
  // axi4-lite write channel: address and data taken in either order
  // ----------------------------------------------------------------
  // ready stays low while frozen, so a handshake is never lost to a stalled clock
  assign AWREADY  = CLK_EN && !aw_held && !BVALID;
  assign WREADY   = CLK_EN && !w_held && !BVALID;
  assign do_write = aw_held && w_held && !BVALID;

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      wr_addr <= 4'h0;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else if (CLK_EN) begin
      if (AWVALID && AWREADY) begin
        aw_held <= 1'b1;
        wr_addr <= AWADDR;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w_held  <= 1'b1;
        wr_data <= WDATA;
        wr_strb <= WSTRB;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      BVALID <= 1'b0;
      BRESP  <= PPAP_RESP_OKAY;
    end else if (CLK_EN) begin
      if (do_write) begin
        BVALID <= 1'b1;
        BRESP  <= (wr_addr[3:2] == PPAP_OFS_STATUS[3:2]) ? PPAP_RESP_SLVERR : PPAP_RESP_OKAY;
      end else if (BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // byte-lane merge for the 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old_v[15:8], s[0] ? d[7:0] : old_v[7:0]};
  endfunction

  always_comb begin
    next_field = 16'h0000;
    if (wr_addr[3:2] == PPAP_OFS_TARGET_ADDR[3:2]) begin
      next_field = merge16(port_target_address, wr_data, wr_strb);
    end else begin
      next_field = merge16(port_pin_function_enable, wr_data, wr_strb);
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      port_target_address <= PPAP_RST_TARGET_ADDR;
    end else if (CLK_EN && do_write && wr_addr[3:2] == PPAP_OFS_TARGET_ADDR[3:2]) begin
      port_target_address <= next_field;                                   // see RL1 RL2 RL3
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      port_pin_function_enable <= PPAP_RST_PIN_ENABLE;
    end else if (CLK_EN && do_write && wr_addr[3:2] == PPAP_OFS_PIN_ENABLE[3:2]) begin
      port_pin_function_enable <= next_field;
    end
  end

  assign start_req = do_write && wr_addr[3:2] == PPAP_OFS_PORT_CTRL[3:2] && wr_strb[0]
                     && wr_data[PPAP_CTRL_START];

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      port_ctrl <= PPAP_RST_PORT_CTRL;
    end else if (CLK_EN && do_write && wr_addr[3:2] == PPAP_OFS_PORT_CTRL[3:2] && wr_strb[0]) begin
      port_ctrl <= wr_data[1:0];
    end
  end

  // ----------------------------------------------------------------
  // transfer timer: a start while busy is ignored
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      busy     <= 1'b0;
      xfer_cnt <= 4'h0;
    end else if (CLK_EN) begin
      if (!busy && start_req) begin
        busy     <= 1'b1;
        xfer_cnt <= PPAP_XFER_CYCLES - 4'h1;
      end else if (busy) begin
        if (xfer_cnt == 4'h0) begin
          busy <= 1'b0;
        end else begin
          xfer_cnt <= xfer_cnt - 4'h1;
        end
      end
    end
  end

  assign TRANSFER_BUSY = busy;

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  assign ARREADY = CLK_EN && !RVALID;

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      RVALID <= 1'b0;
      RDATA  <= 32'h0000_0000;
      RRESP  <= PPAP_RESP_OKAY;
    end else if (CLK_EN) begin
      if (ARVALID && ARREADY) begin
        RVALID <= 1'b1;
        RRESP  <= PPAP_RESP_OKAY;
        unique case (ARADDR[3:2])
          PPAP_OFS_TARGET_ADDR[3:2]: RDATA <= {16'h0000, port_target_address};   // see RL3
          PPAP_OFS_PIN_ENABLE[3:2]:  RDATA <= {16'h0000, port_pin_function_enable};
          PPAP_OFS_PORT_CTRL[3:2]:   RDATA <= {30'h0000_0000, port_ctrl};
          PPAP_OFS_STATUS[3:2]:      RDATA <= {27'h000_0000, xfer_cnt, busy};
        endcase
      end else if (RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin values: address bits or strobes per function select
  // ----------------------------------------------------------------
  logic [15:0] port_value;
  logic        ale_high;
  logic        ale_low;

  // latch strobes pulse in the first transfer cycle only
  assign ale_high = busy && xfer_cnt == PPAP_XFER_CYCLES - 4'h1;
  assign ale_low  = busy && xfer_cnt == PPAP_XFER_CYCLES - 4'h1;

  always_comb begin
    port_value = {2'b00, port_target_address[PPAP_ADDR_MSB:0]};
    if (port_ctrl[PPAP_CTRL_MUX_CS]) begin
      port_value[15] = chip_select_second && busy;                        // see RL4
      port_value[14] = chip_select_first && busy;
    end
    if (port_ctrl[PPAP_CTRL_MUX_ALE]) begin
      port_value[1] = ale_high;                                           // see RL6
      port_value[0] = ale_low;
    end
  end

  // strobe outputs only leave the block on pins enabled for them
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      PORT_CHIP_SELECT_SECOND   <= 1'b0;
      PORT_CHIP_SELECT_FIRST    <= 1'b0;
      ADDRESS_LATCH_HIGH_STROBE <= 1'b0;
      ADDRESS_LATCH_LOW_STROBE  <= 1'b0;
    end else if (CLK_EN) begin
      PORT_CHIP_SELECT_SECOND   <= busy && chip_select_second && upper_pin_strobe_enable[1];   // see RL1
      PORT_CHIP_SELECT_FIRST    <= busy && chip_select_first && upper_pin_strobe_enable[0];    // see RL2
      ADDRESS_LATCH_HIGH_STROBE <= ale_high && lower_pin_latch_enable[1];
      ADDRESS_LATCH_LOW_STROBE  <= ale_low && lower_pin_latch_enable[0];
    end
  end

  ppap_pin_mux u_pin_mux (
    .pin_enable   (port_pin_function_enable),                            // see RL5
    .port_value   (port_value),
    .drive_active (busy),                                                // see RL7
    .gpio_out     (GPIO_OUT),
    .gpio_oe      (GPIO_OE),
    .pad_out      (PORT_ADDRESS_PIN_OUT),
    .pad_oe       (PORT_ADDRESS_PIN_OE)
  );

endmodule // ppap_top

// ==== testbench/ppap_props.sv ====
// checker: port-level properties of the address and pin-enable block
`timescale 1ns/10ps
module ppap_props
  import ppap_pkg::*;
(
  // clock and reset
  input wire logic        MCLK,
  input wire logic        RST,
  // write response
  input wire logic [1:0]  BRESP,
  input wire logic        BVALID,
  input wire logic        BREADY,
  // pads and strobes
  input wire logic [15:0] GPIO_OE,
  input wire logic [15:0] PORT_ADDRESS_PIN_OE,
  input wire logic        PORT_CHIP_SELECT_SECOND,
  input wire logic        PORT_CHIP_SELECT_FIRST,
  input wire logic        ADDRESS_LATCH_HIGH_STROBE,
  input wire logic        ADDRESS_LATCH_LOW_STROBE,
  input wire logic        TRANSFER_BUSY
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  AST_BUSY_LEN: assert property ($rose(TRANSFER_BUSY) |-> TRANSFER_BUSY[*4] ##1 !TRANSFER_BUSY)
    else $error("busy length wrong");
  AST_IDLE_OE: assert property (!TRANSFER_BUSY |-> (PORT_ADDRESS_PIN_OE & ~GPIO_OE) == 16'h0000)
    else $error("pin driven while idle");
  AST_SEL_TWO: assert property (PORT_CHIP_SELECT_SECOND |-> $past(TRANSFER_BUSY))
    else $error("select two outside transfer");
  AST_SEL_ONE: assert property (PORT_CHIP_SELECT_FIRST |-> $past(TRANSFER_BUSY))
    else $error("select one outside transfer");
  AST_LOW_PULSE: assert property (ADDRESS_LATCH_LOW_STROBE |=> !ADDRESS_LATCH_LOW_STROBE)
    else $error("low latch too long");
  AST_HIGH_PULSE: assert property (ADDRESS_LATCH_HIGH_STROBE |=> !ADDRESS_LATCH_HIGH_STROBE)
    else $error("high latch too long");
  AST_HIGH_BUSY: assert property (ADDRESS_LATCH_HIGH_STROBE |-> TRANSFER_BUSY && $past(TRANSFER_BUSY))
    else $error("high latch outside transfer");
  AST_RESP_HOLD: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  cover property ($rose(TRANSFER_BUSY));
  cover property (ADDRESS_LATCH_LOW_STROBE);
  cover property (BVALID && BRESP == PPAP_RESP_SLVERR);
endmodule // ppap_props

bind ppap_top ppap_props u_props (.*);

// ==== testbench/ppap_periph.sv ====
// partner model: peripheral that records what each transfer put on its pins
`timescale 1ns/10ps
module ppap_periph (
  // pins seen from the far side
  input wire logic        mclk,
  input wire logic        busy,
  input wire logic [15:0] pad_out,
  input wire logic [15:0] pad_oe,
  input wire logic [3:0]  strobes,
  // record of the last transfer
  output logic     [15:0] last_out,
  output logic     [15:0] last_oe,
  output logic     [3:0]  seen,
  output logic     [3:0]  len
);
  logic busy_q;
  // flags stick until the next transfer, so chip selects that trail busy are not lost
  always @(posedge mclk) begin
    busy_q <= busy;
    seen <= (busy && !busy_q) ? 4'h0 : seen | strobes;
    len <= (busy && !busy_q) ? 4'h1 : len + {3'h0, busy};
    if (busy) begin
      last_out <= pad_out;
      last_oe <= pad_oe;
    end
  end
endmodule // ppap_periph

// ==== testbench/tb_top.sv ====
// testbench: register access and pin-function transfers of the address block
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top
  import ppap_pkg::*;
();
  logic        MCLK = 1'b0, RST = 1'b1, CLK_EN = 1'b1;
  logic [3:0]  AWADDR = 4'h0, ARADDR = 4'h0, WSTRB = 4'h0;
  logic [31:0] WDATA = 32'h0000_0000, RDATA;
  logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic [15:0] GPIO_OUT = 16'h0000, GPIO_OE = 16'h0000, PORT_ADDRESS_PIN_OUT, PORT_ADDRESS_PIN_OE;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, TRANSFER_BUSY;
  logic        PORT_CHIP_SELECT_SECOND, PORT_CHIP_SELECT_FIRST, ADDRESS_LATCH_HIGH_STROBE, ADDRESS_LATCH_LOW_STROBE;
  logic [1:0]  BRESP, RRESP;
  logic [15:0] m_out, m_oe;
  logic [3:0]  m_seen, m_len;
  int          err_count = 0, checked = 0, cyc = 0;
  ppap_top dut (.*);
  ppap_periph far (.mclk(MCLK), .busy(TRANSFER_BUSY), .pad_out(PORT_ADDRESS_PIN_OUT), .pad_oe(PORT_ADDRESS_PIN_OE),
    .strobes({PORT_CHIP_SELECT_SECOND, PORT_CHIP_SELECT_FIRST, ADDRESS_LATCH_HIGH_STROBE, ADDRESS_LATCH_LOW_STROBE}),
    .last_out(m_out), .last_oe(m_oe), .seen(m_seen), .len(m_len));
  initial forever #12.5 MCLK = ~MCLK;
  // valid is raised first and held until ready is seen; CLK_EN stays high, so the hold-while-stalled case is not exercised
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= s;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    do begin
      @(posedge MCLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
      if (BVALID) BREADY <= 1'b1;
    end while (!(BVALID && BREADY));
    r = BRESP;
    BREADY <= 1'b0;
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] d);
    ARADDR <= a;
    ARVALID <= 1'b1;
    do begin
      @(posedge MCLK);
      if (ARREADY) ARVALID <= 1'b0;
      if (RVALID) RREADY <= 1'b1;
    end while (!(RVALID && RREADY));
    d = RDATA;
    `CHK(RRESP, PPAP_RESP_OKAY)
    RREADY <= 1'b0;
  endtask
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    axr(PPAP_OFS_TARGET_ADDR, d);
    `CHK(d, {16'h0000, PPAP_RST_TARGET_ADDR})
    axr(PPAP_OFS_PIN_ENABLE, d);
    `CHK(d, {16'h0000, PPAP_RST_PIN_ENABLE})
    axw(PPAP_OFS_TARGET_ADDR, 32'h0000_FFFF, 4'hF, r);
    `CHK(r, PPAP_RESP_OKAY)
    axw(PPAP_OFS_TARGET_ADDR, 32'h0000_1234, 4'h1, r);
    axr(PPAP_OFS_TARGET_ADDR, d);
    `CHK(d, 32'h0000_FF34)
    axw(PPAP_OFS_STATUS, 32'h0000_FFFF, 4'hF, r);
    `CHK(r, PPAP_RESP_SLVERR)
  endtask
  task automatic t_xfer(input logic [15:0] en, input logic [15:0] a, input logic [1:0] c);
    logic [31:0] d;
    logic [1:0]  r;
    logic [15:0] gv;
    GPIO_OUT <= ~a;
    GPIO_OE <= {a[7:0], a[15:8]};
    axw(PPAP_OFS_PIN_ENABLE, {16'h0000, en}, 4'h3, r);
    axw(PPAP_OFS_TARGET_ADDR, {16'h0000, a}, 4'h3, r);
    axr(PPAP_OFS_PIN_ENABLE, d);
    `CHK(d[15:0], en)
    axr(PPAP_OFS_TARGET_ADDR, d);
    `CHK(d[15:0], a)
    axw(PPAP_OFS_PORT_CTRL, {29'h0, 1'b1, c}, 4'h1, r);
    // second start lands in the last busy cycle and must not stretch the transfer
    axw(PPAP_OFS_PORT_CTRL, {29'h0, 1'b1, c}, 4'h1, r);
    while (TRANSFER_BUSY) @(posedge MCLK);
    repeat (2) @(posedge MCLK);
    // the model keeps the last busy cycle, where latch-strobe pins are already low again
    gv = {c[0] ? a[15:14] : 2'b00, a[13:2], c[1] ? 2'b00 : a[1:0]};
    `CHK(m_out, (gv & en) | (~a & ~en))
    `CHK(m_oe, en | ({a[7:0], a[15:8]} & ~en))
    `CHK(m_seen, {a[15] & en[15], a[14] & en[14], en[1], en[0]})
    `CHK(m_len, PPAP_XFER_CYCLES)
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      results();
    end
  end
  initial begin
    repeat (8) @(posedge MCLK);
    RST <= 1'b0;
    @(posedge MCLK);
    t_regs();
    t_xfer(16'hFFFF, 16'hC123, 2'h3);
    t_xfer(16'h3FFC, 16'h8ABC, 2'h0);
    t_xfer(16'hC003, 16'h4001, 2'h3);
    t_xfer(16'h0000, 16'hFFFF, 2'h0);
    results();
  end
endmodule // tb_top
